//--- pswd_map.svh
/*
 holds the constants of the pin strobe watchdog: timeout figures,
 clock rate, the derived tick cycle count and the default period select code.
 assumes a 125 MHz mclk; included by its bare name.
*/
`ifndef PSWD_MAP_SVH
`define PSWD_MAP_SVH

`define PSWD_CLK_MHZ        125
// prescaler tick of 1 us keeps the period counter narrow
`define PSWD_TICK_NS        1000
`define PSWD_TICK_CYC       (`PSWD_TICK_NS * `PSWD_CLK_MHZ / 1000)
// watchdog periods, typical, in us
`define PSWD_PER0_US        6300
`define PSWD_PER1_US        102000
`define PSWD_PER2_US        1600000
`define PSWD_PER3_US        25600000
// reset hold time, typical, in us
`define PSWD_HOLD_US        200000
`define PSWD_SEL_DEFAULT    2'h2

`endif

//--- pswd_pkg.sv
/*
 holds the types of the pin strobe watchdog.
 assumes pswd_map.svh for its numbers.
*/
`default_nettype none
package pswd_pkg;
	typedef enum logic [1:0] {
		PSWD_IDLE    = 2'b00,
		PSWD_WATCH   = 2'b01,
		PSWD_HOLD    = 2'b10
	} pswd_state_e;

	typedef logic [1:0]  pswd_sel_t;
	typedef logic [24:0] pswd_cnt_t;
	typedef logic [6:0]  pswd_pre_t;

	typedef struct packed {
		logic        sync1;
		logic        sync2;
		logic        sync3;
	} pswd_sync_s;

	typedef struct packed {
		pswd_state_e state;
		pswd_pre_t   pre;
		pswd_cnt_t   cnt;
		logic        rst_out;
		logic        rst_out_n;
		logic        pullup_en;
		logic        timeout;
	} pswd_core_s;
endpackage
`default_nettype wire

//--- pswd_strobe_sync.sv
/*
 synchroniser and edge detector for the strobe pin.
 assumes the pin may change at any time relative to mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module pswd_strobe_sync
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// pin
	input  wire logic watchdog_strobe_input,
	// edges, one cycle each
	output logic      fall_pulse,
	output logic      any_pulse
);
	import pswd_pkg::*;

	pswd_sync_s sync_reg;
	pswd_sync_s sync_next;

	always_comb
	begin
		sync_next       = sync_reg;
		sync_next.sync1 = watchdog_strobe_input;
		sync_next.sync2 = sync_reg.sync1;
		sync_next.sync3 = sync_reg.sync2;
	end

	// reset to high: pull-up holds the pin high while idle
	always_ff @(posedge mclk)
	begin
		if (rst)
			sync_reg <= '{sync1: 1'b1, sync2: 1'b1, sync3: 1'b1};
		else
			sync_reg <= sync_next;
	end

	assign fall_pulse = sync_reg.sync3 & ~sync_reg.sync2;
	assign any_pulse  = sync_reg.sync3 ^ sync_reg.sync2;
endmodule
`default_nettype wire

//--- pswd_top.sv
/*
 pin strobe watchdog of a supply supervisor: arms on the first
 falling strobe edge, restarts on every edge, forces reset on timeout.
 assumes manual and power-on requests arrive already filtered and
 synchronous to mclk; rst stands for power-on reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pswd_map.svh"

////////////////////////////////////////////////////////////////////////
module pswd_top
#(
	parameter pswd_pkg::pswd_sel_t PERIOD_SEL = `PSWD_SEL_DEFAULT,
	parameter int unsigned         HOLD_US    = `PSWD_HOLD_US,
	parameter int unsigned         TICK_CYC   = `PSWD_TICK_CYC
)
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// strobe pin and its pull-up control
	input  wire logic watchdog_strobe_input,
	output logic      strobe_pullup_en,
	// manual reset request, active high, already filtered
	input  wire logic manual_reset_req,
	// reset outputs
	output logic      sys_reset,
	output logic      sys_reset_n,
	// one-cycle pulse on watchdog timeout
	output logic      timeout_pulse
);
	import pswd_pkg::*;

	////////////////////////////////////////////////////////////////////
	// period selection

	// returns the period in 1 us ticks for a select code
	function automatic pswd_cnt_t period_ticks(input pswd_sel_t sel);
		unique case (sel)
			2'h0: period_ticks = pswd_cnt_t'(`PSWD_PER0_US);
			2'h1: period_ticks = pswd_cnt_t'(`PSWD_PER1_US);
			2'h2: period_ticks = pswd_cnt_t'(`PSWD_PER2_US);
			2'h3: period_ticks = pswd_cnt_t'(`PSWD_PER3_US);
		endcase
	endfunction

	// typical figure used; lies inside the guaranteed window
	localparam pswd_cnt_t PERIOD = period_ticks(PERIOD_SEL);
	localparam pswd_cnt_t HOLD   = pswd_cnt_t'(HOLD_US);
	localparam pswd_pre_t PRE_LAST = pswd_pre_t'(TICK_CYC - 1);

	////////////////////////////////////////////////////////////////////
	// strobe edges

	logic fall_pulse;
	logic any_pulse;

	pswd_strobe_sync u_sync
	(
		.mclk                  (mclk),
		.rst                   (rst),
		.watchdog_strobe_input (watchdog_strobe_input),
		.fall_pulse            (fall_pulse),
		.any_pulse             (any_pulse)
	);

	////////////////////////////////////////////////////////////////////
	// core state

	pswd_core_s core_reg;
	pswd_core_s core_next;
	logic       tick;

	assign tick = (core_reg.pre == PRE_LAST);

	always_comb
	begin
		core_next         = core_reg;
		core_next.timeout = 1'b0;
		core_next.pre     = tick ? '0 : pswd_pre_t'(core_reg.pre + 1'b1);
		unique case (core_reg.state)
			PSWD_IDLE:
			begin
				core_next.pullup_en = 1'b1;
				if (manual_reset_req)
				begin
					core_next.state = PSWD_HOLD;
					core_next.cnt   = HOLD;
					core_next.pre   = '0;
				end
				else if (fall_pulse)
				begin
					core_next.state     = PSWD_WATCH;
					core_next.pullup_en = 1'b0;
					core_next.cnt       = PERIOD;
					core_next.pre       = '0;
				end
			end
			PSWD_WATCH:
			begin
				if (manual_reset_req)
				begin
					core_next.state     = PSWD_HOLD;
					core_next.pullup_en = 1'b1;
					core_next.cnt       = HOLD;
					core_next.pre       = '0;
				end
				else if (any_pulse)
				begin
					// edge reload wins over an expiry in the same cycle
					core_next.cnt = PERIOD;
					core_next.pre = '0;
				end
				else if (tick)
				begin
					if (core_reg.cnt == pswd_cnt_t'(1))
					begin
						core_next.state     = PSWD_HOLD;
						core_next.timeout   = 1'b1;
						core_next.pullup_en = 1'b1;
						core_next.cnt       = HOLD;
					end
					else
						core_next.cnt = pswd_cnt_t'(core_reg.cnt - 1'b1);
				end
			end
			PSWD_HOLD:
			begin
				core_next.pullup_en = 1'b1;
				if (manual_reset_req)
				begin
					core_next.cnt = HOLD;
					core_next.pre = '0;
				end
				else if (tick)
				begin
					if (core_reg.cnt == pswd_cnt_t'(1))
						core_next.state = PSWD_IDLE;
					else
						core_next.cnt = pswd_cnt_t'(core_reg.cnt - 1'b1);
				end
			end
			default:
				core_next.state = PSWD_IDLE;
		endcase
		core_next.rst_out   = (core_next.state == PSWD_HOLD);
		core_next.rst_out_n = ~core_next.rst_out;
	end

	// rst acts as power-on reset: disabled, pull-up on
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			core_reg           <= '0;
			core_reg.state     <= PSWD_IDLE;
			core_reg.pullup_en <= 1'b1;
			core_reg.rst_out_n <= 1'b1;
		end
		else
			core_reg <= core_next;
	end

	assign strobe_pullup_en = core_reg.pullup_en;
	assign sys_reset        = core_reg.rst_out;
	assign sys_reset_n      = core_reg.rst_out_n;
	assign timeout_pulse    = core_reg.timeout;

	////////////////////////////////////////////////////////////////////
	// checks

	property p_arm_on_fall;
		@(posedge mclk) disable iff (rst)
		core_reg.state == PSWD_IDLE && fall_pulse && !manual_reset_req
		|=> core_reg.state == PSWD_WATCH && !strobe_pullup_en;
	endproperty
	a_arm_on_fall: assert property (p_arm_on_fall)
		else $error("watchdog did not arm on falling edge");

	property p_idle_stays;
		@(posedge mclk) disable iff (rst)
		core_reg.state == PSWD_IDLE && !fall_pulse && !manual_reset_req
		|=> core_reg.state == PSWD_IDLE;
	endproperty
	a_idle_stays: assert property (p_idle_stays)
		else $error("watchdog left idle without a falling edge");

	property p_edge_reload;
		@(posedge mclk) disable iff (rst)
		core_reg.state == PSWD_WATCH && any_pulse && !manual_reset_req
		|=> core_reg.cnt == PERIOD && core_reg.pre == '0;
	endproperty
	a_edge_reload: assert property (p_edge_reload)
		else $error("strobe edge did not restart the timeout");

	property p_timeout_reset;
		@(posedge mclk) disable iff (rst)
		timeout_pulse |-> sys_reset && !sys_reset_n
			&& $past(core_reg.state) == PSWD_WATCH;
	endproperty
	a_timeout_reset: assert property (p_timeout_reset)
		else $error("timeout without active reset outputs");

	property p_manual_disable;
		@(posedge mclk) disable iff (rst)
		manual_reset_req |=> core_reg.state == PSWD_HOLD && sys_reset;
	endproperty
	a_manual_disable: assert property (p_manual_disable)
		else $error("manual reset did not disable the watchdog");

	property p_pullup_idle;
		@(posedge mclk) disable iff (rst)
		core_reg.state != PSWD_WATCH |-> strobe_pullup_en;
	endproperty
	a_pullup_idle: assert property (p_pullup_idle)
		else $error("pull-up off while watchdog disabled");

	property p_pullup_watch;
		@(posedge mclk) disable iff (rst)
		core_reg.state == PSWD_WATCH |-> !strobe_pullup_en;
	endproperty
	a_pullup_watch: assert property (p_pullup_watch)
		else $error("pull-up on while watchdog enabled");

	property p_hold_stable;
		@(posedge mclk) disable iff (rst)
		$rose(sys_reset) |=> sys_reset [*8];
	endproperty
	a_hold_stable: assert property (p_hold_stable)
		else $error("reset output released too early");

	property p_outputs_pair;
		@(posedge mclk) disable iff (rst)
		sys_reset == !sys_reset_n;
	endproperty
	a_outputs_pair: assert property (p_outputs_pair)
		else $error("reset outputs disagree");

	c_arm: cover property (@(posedge mclk) disable iff (rst)
		core_reg.state == PSWD_IDLE ##1 core_reg.state == PSWD_WATCH);
	c_timeout: cover property (@(posedge mclk) disable iff (rst)
		timeout_pulse);
	c_release: cover property (@(posedge mclk) disable iff (rst)
		$fell(sys_reset));
endmodule
`default_nettype wire

//--- pswd_host_model.sv
/*
 host model that drives the watchdog strobe pin.
 assumes the bench sets drive_en and drive_lvl just after mclk rises.
*/
`timescale 1ns/1ns
`default_nettype none
module pswd_host_model
(
	// clock
	input  wire logic mclk,
	// host side
	input  wire logic drive_en,
	input  wire logic drive_lvl,
	// pin
	input  wire logic strobe_pullup_en,
	output logic      pin
);
	logic last_reg;

	// released with no pull-up: toggle, since a float must never look stable
	always_comb
	begin
		if (drive_en)
			pin = drive_lvl;
		else if (strobe_pullup_en)
			pin = 1'b1;
		else
			pin = ~last_reg;
	end

	always_ff @(posedge mclk)
		last_reg <= pin;
endmodule
`default_nettype wire

//--- pin_strobe_watchdog_bench.sv
/*
 self-checking bench of the pin strobe watchdog.
 assumes short counts: 2 cycle tick, 6300 tick period, 10 tick hold.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pswd_map.svh"
module pin_strobe_watchdog_bench;
	localparam int PER  = `PSWD_PER0_US;
	localparam int HOLD = 10;
	// two cycles a tick so the prescaler really divides
	localparam int TICK = 2;
	localparam int PCYC = PER * TICK;
	localparam int HCYC = HOLD * TICK;
	logic mclk, rst, hen, hlvl, pin, pull, mreq, sr, srn, tp;
	int   miscompares, comparisons, n;

	pswd_host_model host_u (.mclk(mclk), .drive_en(hen), .drive_lvl(hlvl),
		.strobe_pullup_en(pull), .pin(pin));
	pswd_top #(.PERIOD_SEL(2'h0), .HOLD_US(HOLD), .TICK_CYC(TICK)) dut_u (
		.mclk(mclk), .rst(rst), .watchdog_strobe_input(pin),
		.strobe_pullup_en(pull), .manual_reset_req(mreq),
		.sys_reset(sr), .sys_reset_n(srn), .timeout_pulse(tp));

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	// bounded wait for sys_reset to reach lvl
	task automatic wait_rst(input logic lvl, output int k);
		k = 0;
		while (sr !== lvl && k < PCYC + 100)
		begin
			step(1);
			k++;
		end
		if (sr !== lvl)
		begin
			miscompares++;
			$display("BAD %0t wait for reset output timed out", $time);
			end_of_test();
		end
	endtask

	task automatic arm();
		hen = 1'b1;
		hlvl = 1'b1;
		step(8);
		hlvl = 1'b0;
		step(6);
		chk(pull === 1'b0 && sr === 1'b0, "arm");
	endtask

	task automatic t_idle();
		chk(sr === 1'b0 && srn === 1'b1 && pull === 1'b1, "reset");
		chk(`PSWD_PER0_US == 6300, "period 0");
		chk(`PSWD_PER1_US == 102000, "period 1");
		chk(`PSWD_PER3_US == 25600000, "period 3");
		chk(`PSWD_SEL_DEFAULT === 2'h2, "default select");
		chk(`PSWD_PER2_US == 1600000, "default period");
		step(PCYC + 700);
		chk(sr === 1'b0 && pull === 1'b1 && pin === 1'b1, "idle");
		$display("done idle");
	endtask

	task automatic t_keep();
		arm();
		repeat (4)
		begin
			hlvl = ~hlvl;
			step(PER / 2);
		end
		chk(sr === 1'b0 && pull === 1'b0, "kept alive");
		$display("done keep");
	endtask

	task automatic t_expire();
		hlvl = ~hlvl;
		wait_rst(1'b1, n);
		chk(n >= PCYC && n <= PCYC + 8, "expiry time");
		chk(tp === 1'b1 && srn === 1'b0 && pull === 1'b1, "expiry");
		hlvl = ~hlvl;
		step(1);
		chk(tp === 1'b0, "pulse width");
		wait_rst(1'b0, n);
		chk(n >= HCYC - 3 && n <= HCYC + 3, "hold");
		chk(srn === 1'b1 && pull === 1'b1, "release");
		$display("done expire");
	endtask

	task automatic t_manual();
		arm();
		mreq = 1'b1;
		step(1);
		mreq = 1'b0;
		chk(sr === 1'b1 && pull === 1'b1, "manual");
		wait_rst(1'b0, n);
		chk(n >= HCYC - 3 && n <= HCYC + 3, "manual hold");
		chk(pull === 1'b1, "manual pull-up");
		$display("done manual");
	endtask

	// power-on reset in mid-watch must disarm and reconnect the pull-up
	task automatic t_por();
		arm();
		hlvl = 1'b1;
		step(8);
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		step(1);
		chk(sr === 1'b0 && srn === 1'b1 && pull === 1'b1, "por");
		step(PCYC + 100);
		chk(sr === 1'b0 && tp === 1'b0 && pull === 1'b1, "por idle");
		$display("done por");
	endtask

	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		miscompares = 0;
		comparisons = 0;
		rst = 1'b1;
		hen = 1'b0;
		hlvl = 1'b1;
		mreq = 1'b0;
		step(16);
		rst = 1'b0;
		step(1);
		t_idle();
		t_keep();
		t_expire();
		t_por();
		t_manual();
		end_of_test();
	end
endmodule
`default_nettype wire
